// ---- rtl/ajcp_params.svh ----
// offsets, field positions, reset values and timing counts of the job control port
`ifndef AJCP_PARAMS_SVH
`define AJCP_PARAMS_SVH
`define AJCP_CLK_HZ 25000000
`define AJCP_HOLD_MS 2000
`define AJCP_DEB_MS 1
`define AJCP_HOLD_CYC ((`AJCP_CLK_HZ / 1000) * `AJCP_HOLD_MS)
`define AJCP_DEB_CYC ((`AJCP_CLK_HZ / 1000) * `AJCP_DEB_MS)
`define AJCP_PWR_SETTLE 4
`define AJCP_OFS_CTRL 8'h00
`define AJCP_OFS_RESULT 8'h04
`define AJCP_OFS_STATUS 8'h08
`define AJCP_OFS_IRQ_STAT 8'h0C
`define AJCP_OFS_IRQ_MASK 8'h10
`define AJCP_OFS_TX_DATA 8'h14
`define AJCP_OFS_BAUD 8'h18
`define AJCP_CTRL_LAUNCH 0
`define AJCP_CTRL_STOP 1
`define AJCP_CTRL_SA_CLR 2
`define AJCP_RES_PASS 0
`define AJCP_RES_FAIL 1
`define AJCP_EV_START 0
`define AJCP_EV_END 1
`define AJCP_EV_SA 2
`define AJCP_EV_TX 3
`define AJCP_PIN_RST 7'h20
`define AJCP_BAUD_RST 16'h00D9
`endif

// ---- rtl/ajcp_pkg.sv ----
// types shared by the job control port
package ajcp_pkg;
  typedef enum logic [0:0] {ST_IDLE, ST_RUN} ajcp_state_type;
  typedef struct packed {
    logic go;
    logic stop;
    logic [4:0] idx;
  } ajcp_job_type;
  typedef struct packed {
    logic strap;
    logic launch_n;
    logic [4:0] sel;
  } ajcp_pins_type;
endpackage

// ---- rtl/ajcp_top.sv ----
// job control port: pin conditioning, job sequencing, status pins, serial tx, ahb-lite registers
// How it works
// - five selector lines pick one of 32 stored jobs
// - job index is the plain binary value of the selector lines
// - selector lines are active high, high gives a one
// - launch input low starts a job, or stops a running one
// - launch held asserted over two seconds enters standalone mode
// - strap high when sampled after power-on enters standalone mode
// - pass output driven low for a good result, high otherwise
// - busy output driven low while occupied, high otherwise
// - fail output driven low on error, high otherwise
// - serial transmit line carries data toward the computer
//
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`include "ajcp_params.svh"
module ajcp_top import ajcp_pkg::*; #(
  parameter int HOLD_CYC = `AJCP_HOLD_CYC,
  parameter int DEB_CYC = `AJCP_DEB_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // control port pins
  input wire ajcp_pins_type pins,
  output logic occupied_flag_n,
  output logic pass_flag_n,
  output logic fail_flag_n,
  output logic serial_tx,
  // toward the programming engine
  output ajcp_job_type job,
  output logic standalone,
  output logic irq
);

  if (DEB_CYC < 1) begin : g_chk_deb
    $error("ajcp_top: DEB_CYC must be at least one");
  end
  if (HOLD_CYC <= DEB_CYC || HOLD_CYC >= 67108863) begin : g_chk_hold
    $error("ajcp_top: HOLD_CYC out of range");
  end

  // three-stage synchroniser
  ajcp_pins_type s1_q, s2_q, s3_q, agr_q, deb_q;
  logic [25:0] deb_cnt_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= `AJCP_PIN_RST;
      s2_q <= `AJCP_PIN_RST;
      s3_q <= `AJCP_PIN_RST;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a bit changes only once stages two and three agree
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      agr_q <= `AJCP_PIN_RST;
    end else begin
      agr_q <= (s3_q & ~(s2_q ^ s3_q)) | (agr_q & (s2_q ^ s3_q));
    end
  end

  // debounce: the agreed vector must differ from deb_q for DEB_CYC cycles in a row
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      deb_q <= `AJCP_PIN_RST;
      deb_cnt_q <= 26'h0000000;
    end else if (agr_q == deb_q) begin
      deb_cnt_q <= 26'h0000000;
    end else if (deb_cnt_q >= 26'(DEB_CYC - 1)) begin
      deb_q <= agr_q;
      deb_cnt_q <= 26'h0000000;
    end else begin
      deb_cnt_q <= deb_cnt_q + 26'h0000001;
    end
  end

  // ahb-lite: address phase captured, one wait state, then the answer
  logic pend_q, wr_q;
  logic [7:0] addr_q;
  wire logic take = hsel & htrans[1] & hready;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend_q <= 1'b0;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout <= 1'b1;
    end else if (pend_q) begin
      pend_q <= 1'b0;
      hreadyout <= 1'b1;
    end else if (take) begin
      pend_q <= 1'b1;
      wr_q <= hwrite;
      addr_q <= {haddr[7:2], 2'b00};
      hreadyout <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  wire logic wr = pend_q & wr_q;
  wire logic wr_ctrl = wr && addr_q == `AJCP_OFS_CTRL;
  wire logic wr_res = wr && addr_q == `AJCP_OFS_RESULT;
  wire logic wr_istat = wr && addr_q == `AJCP_OFS_IRQ_STAT;
  wire logic wr_imask = wr && addr_q == `AJCP_OFS_IRQ_MASK;
  wire logic wr_tx = wr && addr_q == `AJCP_OFS_TX_DATA;
  wire logic wr_baud = wr && addr_q == `AJCP_OFS_BAUD;

  // power-on strap capture, once the conditioned pins have settled
  logic [26:0] pwr_cnt_q;
  logic strap_done_q;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_cnt_q <= 27'h0000000;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      pwr_cnt_q <= pwr_cnt_q + 27'h0000001;
      strap_done_q <= pwr_cnt_q >= 27'(DEB_CYC + `AJCP_PWR_SETTLE);
    end
  end
  // the strap is looked at in one cycle, just as the conditioned pins settle
  wire logic strap_hit = !strap_done_q && pwr_cnt_q >= 27'(DEB_CYC + `AJCP_PWR_SETTLE)
    && deb_q.strap;

  // launch edge and hold timer
  logic launch_prev_q;
  logic [25:0] hold_cnt_q;
  // the count stops one past the limit, so the hold fires only once
  wire logic launch_act = ~deb_q.launch_n;
  wire logic launch_edge = launch_act & ~launch_prev_q;
  wire logic hold_hit = launch_act && hold_cnt_q == 26'(HOLD_CYC);
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      launch_prev_q <= 1'b0;
      hold_cnt_q <= 26'h0000000;
    end else begin
      launch_prev_q <= launch_act;
      if (!launch_act) begin
        hold_cnt_q <= 26'h0000000;
      end else if (hold_cnt_q <= 26'(HOLD_CYC)) begin
        hold_cnt_q <= hold_cnt_q + 26'h0000001;
      end
    end
  end

  // standalone mode flag
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      standalone <= 1'b0;
    end else if (strap_hit || hold_hit) begin
      standalone <= 1'b1;
    end else if (wr_ctrl && hwdata[`AJCP_CTRL_SA_CLR]) begin
      standalone <= 1'b0;
    end
  end

  // job sequencer
  // a stop, from the pin or from software, ends the job as a fail
  ajcp_state_type state_q;
  wire logic do_start = state_q == ST_IDLE &&
    (launch_edge || (wr_ctrl && hwdata[`AJCP_CTRL_LAUNCH]));
  wire logic do_stop = state_q == ST_RUN &&
    (launch_edge || (wr_ctrl && hwdata[`AJCP_CTRL_STOP]));
  wire logic do_pass = state_q == ST_RUN && !do_stop && wr_res && hwdata[`AJCP_RES_PASS]
    && !hwdata[`AJCP_RES_FAIL];
  wire logic do_fail = state_q == ST_RUN &&
    (do_stop || (wr_res && hwdata[`AJCP_RES_FAIL]));
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (do_start) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (do_pass || do_fail) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // job request toward the engine, index latched at launch
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      job <= '0;
    end else begin
      job.go <= do_start;
      job.stop <= do_stop;
      if (do_start) begin
        job.idx <= deb_q.sel;
      end
    end
  end

  // status pins, active low
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      occupied_flag_n <= 1'b1;
      pass_flag_n <= 1'b1;
      fail_flag_n <= 1'b1;
    end else if (do_start) begin
      occupied_flag_n <= 1'b0;
      pass_flag_n <= 1'b1;
      fail_flag_n <= 1'b1;
    end else if (do_pass) begin
      occupied_flag_n <= 1'b1;
      pass_flag_n <= 1'b0;
    end else if (do_fail) begin
      occupied_flag_n <= 1'b1;
      fail_flag_n <= 1'b0;
    end
  end

  // serial transmitter, 8 data bits, no parity, one stop bit
  logic [15:0] baud_q, baud_cnt_q;
  logic [9:0] tx_sh_q;
  logic [3:0] tx_bits_q;
  logic tx_busy_q;
  wire logic tx_tick = baud_cnt_q == 16'h0000;
  wire logic tx_end = tx_busy_q && tx_tick && tx_bits_q == 4'h0;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      baud_q <= `AJCP_BAUD_RST;
    end else if (wr_baud && hwdata[15:0] != 16'h0000) begin
      baud_q <= hwdata[15:0];
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tx_busy_q <= 1'b0;
      tx_sh_q <= 10'h3FF;
      tx_bits_q <= 4'h0;
      baud_cnt_q <= 16'h0000;
      serial_tx <= 1'b1;
    end else if (!tx_busy_q) begin
      serial_tx <= 1'b1;
      if (wr_tx) begin
        tx_busy_q <= 1'b1;
        tx_sh_q <= {1'b1, hwdata[7:0], 1'b0};
        tx_bits_q <= 4'hA;
        baud_cnt_q <= 16'h0000;
      end
    end else if (tx_tick) begin
      serial_tx <= tx_sh_q[0];
      tx_sh_q <= {1'b1, tx_sh_q[9:1]};
      tx_bits_q <= tx_bits_q - 4'h1;
      baud_cnt_q <= baud_q - 16'h0001;
      // the stop bit keeps a whole bit time before the line is free again
      tx_busy_q <= tx_bits_q != 4'h0;
    end else begin
      baud_cnt_q <= baud_cnt_q - 16'h0001;
    end
  end

  // interrupt status, write one to clear, a new event wins
  logic [3:0] istat_q, imask_q, ev, istat_d;
  always_comb begin
    ev = 4'h0;
    ev[`AJCP_EV_START] = do_start;
    ev[`AJCP_EV_END] = do_pass | do_fail;
    ev[`AJCP_EV_SA] = (strap_hit | hold_hit) & ~standalone;
    ev[`AJCP_EV_TX] = tx_end;
    istat_d = istat_q;
    if (wr_istat) begin
      istat_d = istat_q & ~hwdata[3:0];
    end
    istat_d = istat_d | ev;
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      istat_q <= 4'h0;
      imask_q <= 4'h0;
      irq <= 1'b0;
    end else begin
      istat_q <= istat_d;
      if (wr_imask) begin
        imask_q <= hwdata[3:0];
      end
      irq <= |(istat_d & (wr_imask ? hwdata[3:0] : imask_q));
    end
  end

  // read data
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata <= 32'h00000000;
    end else if (pend_q && !wr_q) begin
      case (addr_q)
        `AJCP_OFS_STATUS: begin
          hrdata <= {16'h0000, 3'h0, job.idx, 1'b0,
            deb_q.launch_n, deb_q.strap, standalone,
            ~fail_flag_n, ~pass_flag_n, ~occupied_flag_n, tx_busy_q};
        end
        `AJCP_OFS_IRQ_STAT: begin
          hrdata <= {28'h0000000, istat_q};
        end
        `AJCP_OFS_IRQ_MASK: begin
          hrdata <= {28'h0000000, imask_q};
        end
        `AJCP_OFS_TX_DATA: begin
          hrdata <= {23'h000000, tx_busy_q, 8'h00};
        end
        `AJCP_OFS_BAUD: begin
          hrdata <= {16'h0000, baud_q};
        end
        default: begin
          hrdata <= 32'h00000000;
        end
      endcase
    end
  end

endmodule

// ---- verif/ajcp_asserts.sv ----
// assertions on the job control port outputs
`timescale 1ns/10ps
module ajcp_asserts import ajcp_pkg::*; (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // bus
  input wire logic hreadyout,
  input wire logic hresp,
  // status pins and job
  input wire logic occupied_flag_n,
  input wire logic pass_flag_n,
  input wire logic fail_flag_n,
  input wire ajcp_job_type job
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence busy_s;
    !occupied_flag_n [*2];
  endsequence
  busy_at_go_a: assert property (job.go |-> ##[0:1] busy_s)
    else $error("busy not shown at job start");
  go_pulse_a: assert property (job.go |=> !job.go)
    else $error("start pulse too long");
  go_idle_a: assert property (job.go |-> $past(occupied_flag_n))
    else $error("start while busy");
  one_result_a: assert property (pass_flag_n || fail_flag_n)
    else $error("pass and fail together");
  stop_fail_a: assert property (job.stop |-> ##[0:1] (!fail_flag_n && occupied_flag_n))
    else $error("stop did not end as fail");
  start_clear_a: assert property ($fell(occupied_flag_n) |=> pass_flag_n && fail_flag_n)
    else $error("old result kept at start");
  end_result_a: assert property ($rose(occupied_flag_n) |-> ##[0:1] (pass_flag_n ^ fail_flag_n))
    else $error("job ended without one result");
  idx_hold_a: assert property (!occupied_flag_n && !$past(occupied_flag_n) |-> $stable(job.idx))
    else $error("job index moved during job");
  ready_pulse_a: assert property ($fell(hreadyout) |=> hreadyout)
    else $error("wait state too long");
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("error response");
endmodule

// ---- verif/ajcp_fixture.sv ----
// behavioural ate fixture driving the control port pins
`timescale 1ns/10ps
module ajcp_fixture import ajcp_pkg::*; (
  // clock
  input wire logic core_clk,
  // requests from the bench
  input wire logic [4:0] sel_req,
  input wire logic launch_req,
  input wire logic strap_req,
  // control port pins
  output ajcp_pins_type pins
);
  initial pins = 7'h20;
  // pins change just after the edge, like a real fixture output
  always @(posedge core_clk) begin
    pins.sel <= sel_req;
    pins.launch_n <= ~launch_req;
    pins.strap <= strap_req;
  end
endmodule

// ---- verif/test_ate_job_control_port.sv ----
// self-checking bench of the job control port
`timescale 1ns/10ps
module test_ate_job_control_port;
  import ajcp_pkg::*;
  localparam int HOLD = 200;
  localparam int DEB = 4;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [4:0] sel_req = 5'h00;
  logic launch_req = 1'b0;
  logic strap_req = 1'b0;
  logic [4:0] sels [3] = '{5'h00, 5'h04, 5'h1F};
  logic hreadyout, hresp, occupied_flag_n, pass_flag_n, fail_flag_n, serial_tx, standalone, irq;
  logic [31:0] hrdata;
  ajcp_pins_type pins;
  ajcp_job_type job;
  int fails = 0;
  int total_checks = 0;
  always #20 core_clk = ~core_clk;
  ajcp_fixture ajcp_fixture_inst (.core_clk(core_clk), .sel_req(sel_req),
    .launch_req(launch_req), .strap_req(strap_req), .pins(pins));
  ajcp_top #(.HOLD_CYC(HOLD), .DEB_CYC(DEB)) ajcp_top_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pins(pins), .occupied_flag_n(occupied_flag_n),
    .pass_flag_n(pass_flag_n), .fail_flag_n(fail_flag_n), .serial_tx(serial_tx),
    .job(job), .standalone(standalone), .irq(irq));
  function automatic logic [1:0] exp_flags(input logic good);
    return good ? 2'h1 : 2'h2;
  endfunction
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    q = hrdata;
  endtask
  task start_job(input logic [4:0] s);
    int n;
    n = 0;
    sel_req <= s;
    launch_req <= 1'b1;
    @(posedge core_clk);
    while (job.go !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      n++;
    end
    chk("job index", 32'(job.idx), 32'(s));
    launch_req <= 1'b0;
    tick(15);
    chk("busy pin", 32'(occupied_flag_n), 32'h0);
  endtask
  initial begin
    tick(20000);
    fails++;
    stop_test;
  end
  initial begin
    logic [31:0] q;
    logic [4:0] s;
    logic [7:0] b;
    logic g;
    int n;
    void'($urandom(49472));
    tick(4);
    sys_rst <= 1'b0;
    tick(1);
    chk("idle flags", 32'({occupied_flag_n, pass_flag_n, fail_flag_n}), 32'h7);
    chk("no strap", 32'(standalone), 32'h0);
    bus(1'b1, 32'h10, 32'h2, q);
    bus(1'b0, 32'h40, 32'h0, q);
    chk("unmapped", q, 32'h0);
    for (int i = 0; i < 6; i++) begin
      s = (i < 3) ? sels[i] : 5'($urandom);
      g = 1'($urandom);
      start_job(s);
      sel_req <= 5'($urandom);
      bus(1'b0, 32'h08, 32'h0, q);
      chk("status", 32'({q[12:8], q[1]}), 32'({s, 1'b1}));
      bus(1'b1, 32'h04, g ? 32'h1 : 32'h2, q);
      tick(1);
      chk("result", 32'({pass_flag_n, fail_flag_n}), 32'(exp_flags(g)));
      chk("done", 32'({occupied_flag_n, irq}), 32'h3);
      bus(1'b1, 32'h0C, 32'hF, q);
      tick(1);
      chk("irq cleared", 32'(irq), 32'h0);
    end
    chk("short launch", 32'(standalone), 32'h0);
    start_job(5'h0A);
    launch_req <= 1'b1;
    tick(20);
    chk("stopped", 32'({occupied_flag_n, fail_flag_n}), 32'h2);
    launch_req <= 1'b0;
    sel_req <= 5'h03;
    tick(15);
    launch_req <= 1'b1;
    tick(HOLD + 40);
    chk("held launch", 32'({standalone, occupied_flag_n}), 32'h2);
    launch_req <= 1'b0;
    tick(15);
    bus(1'b1, 32'h04, 32'h1, q);
    bus(1'b1, 32'h00, 32'h4, q);
    tick(1);
    chk("mode cleared", 32'(standalone), 32'h0);
    bus(1'b0, 32'h10, 32'h0, q);
    chk("irq mask", q, 32'h2);
    bus(1'b1, 32'h00, 32'h1, q);
    tick(1);
    chk("soft start", 32'({occupied_flag_n, pass_flag_n, fail_flag_n}), 32'h3);
    bus(1'b1, 32'h00, 32'h2, q);
    tick(1);
    chk("soft stop", 32'({occupied_flag_n, fail_flag_n}), 32'h2);
    bus(1'b1, 32'h18, 32'h4, q);
    bus(1'b0, 32'h18, 32'h0, q);
    chk("baud", q, 32'h4);
    bus(1'b1, 32'h14, 32'hA5, q);
    n = 0;
    while (serial_tx !== 1'b0 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    tick(1);
    for (int i = 0; i < 8; i++) begin
      tick(4);
      b[i] = serial_tx;
    end
    tick(4);
    chk("tx byte", 32'({serial_tx, b}), 32'h1A5);
    strap_req <= 1'b1;
    sys_rst <= 1'b1;
    tick(4);
    sys_rst <= 1'b0;
    tick(DEB + 30);
    chk("strap mode", 32'(standalone), 32'h1);
    chk("reset flags", 32'({occupied_flag_n, pass_flag_n, fail_flag_n}), 32'h7);
    stop_test;
  end
endmodule
bind ajcp_top ajcp_asserts ajcp_asserts_inst (.core_clk(core_clk), .sys_rst(sys_rst),
  .hreadyout(hreadyout), .hresp(hresp), .occupied_flag_n(occupied_flag_n),
  .pass_flag_n(pass_flag_n), .fail_flag_n(fail_flag_n), .job(job));
